// File: src/serial_config_memory.sv
/*
 * read side of a one-bit serial configuration memory: read pointer, standby,
 * cascade chain select and programming mode entry.
 * assumes config_clock, chip select and gate pins are synchronous to core_clk;
 * the stored image arrives on a parallel port from the storage array.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_config_memory #(
    parameter int unsigned DEPTH = prom_readout_pkg::DEFAULT_DEPTH,
    parameter int unsigned PW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // configuration link pins
    input  wire logic             config_clock,
    input  wire logic             chip_select_n,
    input  wire logic             reset_gate,
    input  wire logic             prog_supply,
    // stored image
    input  wire logic [DEPTH-1:0] image,
    // data pin, split two ways
    output logic                  dataOut,
    output logic                  dataOe,
    // cascade and status
    output logic                  chain_select_out_n,
    output logic                  programMode,
    output logic [PW-1:0]         readPointer
);
    // mode register and its next value
    // read, exhausted after the last bit, or programming until power goes
    prom_readout_pkg::mode_t mode_ff;
    prom_readout_pkg::mode_t nxt_mode;

    // read pointer: address and bit counters folded into one index
    // one index is cheaper than two counters and makes the end test exact
    logic [PW-1:0]           ptr_ff;
    logic [PW-1:0]           nxt_ptr;

    // gate history for the cascade output
    logic                    gateHeld_ff;
    logic                    nxt_gateHeld;

    // count of clock edges seen with the programming supply high
    // two bits are enough: the count saturates at the entry threshold
    logic [1:0]              vppCount_ff;
    logic [1:0]              nxt_vppCount;

    // decoded pin and state conditions
    logic                    clkRise;
    logic                    selected;
    logic                    gateLow;
    logic                    advance;
    logic                    lastBit;
    logic                    exhausted;
    logic                    progActive;
    logic                    vppReached;
    logic                    driveEnable;
    logic [PW-1:0]           stepPtr;

    // programming mode is the one state that only power removal leaves
    function automatic logic is_program(input prom_readout_pkg::mode_t m);
        is_program = (m == prom_readout_pkg::PROGRAM_ST);
    endfunction

    // pointer plus one, or back to zero after the last stored bit
    function automatic logic [PW-1:0] next_index(input logic [PW-1:0] p,
                                                 input logic          wrap);
        next_index = wrap ? '0 : p + PW'(1);
    endfunction

    // the configuration clock is a plain pin level here; only its rising
    // edge counts, and a level held high never advances twice
    edge_detect u_edge (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .level    (config_clock),
        .rise     (clkRise)
    );

    // pin decode; chip select high is standby
    assign selected    = ~chip_select_n;
    assign gateLow     = ~reset_gate;
    assign advance     = clkRise & selected & gateLow;
    assign lastBit     = (ptr_ff == PW'(DEPTH - 1));
    assign exhausted   = (mode_ff == prom_readout_pkg::EXHAUSTED_ST);
    assign progActive  = is_program(mode_ff);
    assign stepPtr     = next_index(ptr_ff, lastBit & progActive);

    // supply counted as reached once enough edges have passed with it high
    assign vppReached  = (vppCount_ff >= 2'(prom_readout_pkg::PROG_EDGES));

    // pointer and mode next value: gate high clears, a rise advances;
    // in standby rises are ignored so the counters are held
    always_comb begin
        nxt_ptr  = ptr_ff;
        nxt_mode = mode_ff;
        if (reset_gate) begin
            nxt_ptr = '0;
            if (!progActive) begin
                nxt_mode = prom_readout_pkg::READ_ST;
            end
        end else if (advance) begin
            case (mode_ff)
                prom_readout_pkg::READ_ST: begin
                    if (lastBit) begin
                        nxt_mode = prom_readout_pkg::EXHAUSTED_ST;
                    end else begin
                        nxt_ptr = stepPtr;
                    end
                end
                prom_readout_pkg::PROGRAM_ST: begin
                    nxt_ptr = stepPtr;
                end
                prom_readout_pkg::EXHAUSTED_ST: begin
                    nxt_ptr = ptr_ff; // nothing more to read
                end
                default: begin
                    nxt_mode = prom_readout_pkg::READ_ST;
                end
            endcase
        end
        // entry wins over everything else and is never undone here
        if (vppReached) begin
            nxt_mode = prom_readout_pkg::PROGRAM_ST;
        end
    end

    // supply must stay high across the counted edges; a drop starts over
    always_comb begin
        nxt_vppCount = vppCount_ff;
        if (!prog_supply) begin
            nxt_vppCount = 2'h0;
        end else if (clkRise && !vppReached) begin
            nxt_vppCount = vppCount_ff + 2'h1;
        end
    end

    // a gate rise blocks chain select until a full read-out ends again
    // the gate setting wins when both fall in one cycle
    always_comb begin
        nxt_gateHeld = gateHeld_ff;
        if (reset_gate) begin
            nxt_gateHeld = 1'b1;
        end else if (advance && lastBit && !exhausted && !progActive) begin
            nxt_gateHeld = 1'b0;
        end
    end

    // counters only clear on reset, gate high or a wrap in programming mode, so a held-low gate keeps
    // them across loads and the next load resumes there
    // limitation: an aborted load needs the gate pulsed by outside logic
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_ff      <= '0;
            mode_ff     <= prom_readout_pkg::READ_ST;
            vppCount_ff <= 2'h0;
            gateHeld_ff <= prom_readout_pkg::POINTER_RESET;
        end else begin
            ptr_ff      <= nxt_ptr;
            mode_ff     <= nxt_mode;
            vppCount_ff <= nxt_vppCount;
            gateHeld_ff <= nxt_gateHeld;
        end
    end

    // driver only when selected, gate low, not exhausted, not programming
    // the programming data path is not modelled, so the pin stays released
    assign driveEnable = selected & gateLow & ~exhausted & ~progActive;
    assign dataOe      = driveEnable;

    // the bit is read from the array at the pointer flip-flops, so bit zero
    // already stands when the loader raises its first clock after reset
    // a registered copy would show a stale bit in that first cycle
    assign dataOut     = image[ptr_ff];

    // chain select follows chip select once the last bit is gone
    // a downstream device sees this as its own chip select
    assign chain_select_out_n = ~(exhausted & selected & gateLow & ~gateHeld_ff);

    // status
    assign programMode = progActive;
    assign readPointer = ptr_ff;
endmodule
`default_nettype wire

// File: pkg/prom_readout_pkg.sv
/*
 * constants and types for the serial configuration memory read-out block.
 * assumes one clock (core_clk) that samples the configuration clock pin as
 * an ordinary synchronous input.
 */
package prom_readout_pkg;
    localparam int unsigned DEFAULT_DEPTH  = 32'h00008000; // stored bits; plain default, set per part
    localparam int unsigned PROG_EDGES     = 2;     // clock edges with supply high
    localparam logic        POINTER_RESET  = 1'b0;
    typedef enum logic [1:0] {READ_ST, EXHAUSTED_ST, PROGRAM_ST} mode_t;
endpackage

// File: src/edge_detect.sv
/*
 * rising edge detector for the configuration clock pin.
 * assumes the pin is already synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // sampled level and its rising edge
    input  wire logic level,
    output logic      rise
);
    logic prev_ff;

    // previous level, reset to the pin's idle low level so reset makes no false edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    assign rise = level & ~prev_ff;
endmodule
`default_nettype wire

// File: verification/serial_config_memory_asserts.sv
/* port checker for serial_config_memory.
   assumes one clock domain; bound to the design top below. */
`timescale 1ns/1ps
`default_nettype none
module serial_config_memory_chk #(parameter int unsigned DEPTH = 8, PW = 3) (
    // watched ports
    input wire logic core_clk, arst_n, config_clock, chip_select_n, reset_gate, prog_supply,
    input wire logic [DEPTH-1:0] image,
    input wire logic dataOut, dataOe, chain_select_out_n, programMode,
    input wire logic [PW-1:0] readPointer
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // each property ties an output to its cause at the pins
    property p_oe; dataOe |-> !chip_select_n && !reset_gate; endproperty
    a_oe: assert property (p_oe) else $error("data driven while off");
    property p_hold; chip_select_n && !reset_gate |=> $stable(readPointer); endproperty
    a_hold: assert property (p_hold) else $error("pointer moved in standby");
    property p_clr; reset_gate |=> readPointer == '0; endproperty
    a_clr: assert property (p_clr) else $error("gate did not clear");
    property p_adv; config_clock && !$past(config_clock) && !chip_select_n && !reset_gate
        && !programMode && readPointer < PW'(DEPTH-1) |=> readPointer == $past(readPointer) + 1'b1;
    endproperty
    a_adv: assert property (p_adv) else $error("pointer did not advance");
    property p_ceo; !chain_select_out_n |-> !dataOe && !chip_select_n && !reset_gate; endproperty
    a_ceo: assert property (p_ceo) else $error("chain select wrong");
    property p_dat; dataOe |-> dataOut == image[readPointer]; endproperty
    a_dat: assert property (p_dat) else $error("wrong data bit");
    property p_prog; $rose(programMode) |-> $past(prog_supply); endproperty
    a_prog: assert property (p_prog) else $error("program mode without supply");
    property p_rst; $rose(arst_n) |-> readPointer == '0; endproperty
    a_rst: assert property (p_rst) else $error("pointer not cleared");
    c_ceo: cover property (!chain_select_out_n);
    c_prog: cover property ($rose(programMode));
    c_stby: cover property (chip_select_n && config_clock);
endmodule
bind serial_config_memory serial_config_memory_chk #(.DEPTH(DEPTH), .PW(PW)) chk_u (.*);
`default_nettype wire

// File: verification/config_loader.sv
/* loader model: makes config_clock and shifts in the data line.
   assumes core_clk from the bench; the data line has a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module config_loader (
    input wire logic core_clk, dataOut, dataOe,
    output logic config_clock
);
    logic [15:0] rxBits = 16'h0000;
    wire logic dinLine = dataOe ? dataOut : 1'b1; // released line floats up
    initial config_clock = 1'b0;
    // one pulse per bit; the bit is taken as the clock rises, before the
    // memory moves on; lowCyc slows the loader down
    task automatic pulse(input int n, input int lowCyc);
        repeat (n) begin
            @(negedge core_clk);
            rxBits = {rxBits[14:0], dinLine};
            config_clock = 1'b1;
            @(negedge core_clk) config_clock = 1'b0;
            repeat (lowCyc) @(negedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// File: verification/test_serial_config_prom_readout.sv
/* bench for serial_config_memory with an 8-bit image and the loader model.
   assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module test_serial_config_prom_readout;
    localparam logic [7:0] IMG = 8'hb5;
    logic core_clk = 1'b0, arst_n = 1'b0, chip_select_n = 1'b0, reset_gate = 1'b0;
    logic prog_supply = 1'b0;
    logic config_clock, dataOut, dataOe, chain_select_out_n, programMode;
    logic [2:0] readPointer;
    int err_total = 0, n_checks = 0;
    initial forever #4 core_clk = ~core_clk;
    serial_config_memory #(.DEPTH(8)) dut_u (.core_clk, .arst_n, .config_clock,
        .chip_select_n, .reset_gate, .prog_supply, .image(IMG), .dataOut, .dataOe,
        .chain_select_out_n, .programMode, .readPointer);
    config_loader ldr_u (.core_clk, .dataOut, .dataOe, .config_clock);
    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // full read-out, bit order, then the end of memory
    task automatic t_read;
        logic [7:0] exp = 8'h00;
        chk("ptr", 8'h00, readPointer);
        chk("bit0", IMG[0], dataOut);
        for (int i = 0; i < 8; i++) exp = {exp[6:0], IMG[i]};
        ldr_u.pulse(8, 0);
        chk("bits", exp, ldr_u.rxBits[7:0]);
        chk("ceo", 8'h00, chain_select_out_n);
        chk("oe", 8'h00, dataOe);
    endtask
    // gate clears, standby holds and floats, select re-enables
    task automatic t_standby;
        reset_gate = 1'b1;
        @(negedge core_clk) chk("ptr", 8'h00, readPointer);
        chk("ceo", 8'h01, chain_select_out_n);
        reset_gate = 1'b0;
        chip_select_n = 1'b1;
        ldr_u.pulse(3, 0);
        chk("ptr", 8'h00, readPointer);
        chk("oe", 8'h00, dataOe);
        chip_select_n = 1'b0;
        @(negedge core_clk) chk("oe", 8'h01, dataOe);
    endtask
    // counters kept over a pause, reading resumes where it stopped
    task automatic t_resume;
        ldr_u.pulse(3, 0);
        repeat (6) @(negedge core_clk);
        chk("ptr", 8'h03, readPointer);
        ldr_u.pulse(2, 1);
        chk("ptr", 8'h05, readPointer);
        chk("bits", {6'h00, IMG[3], IMG[4]}, {6'h00, ldr_u.rxBits[1:0]});
    endtask
    // program mode entry is sticky until power goes
    task automatic t_prog;
        prog_supply = 1'b1; // chip select left alone while programming
        ldr_u.pulse(2, 1);
        chk("prog", 8'h01, programMode);
        prog_supply = 1'b0;
        ldr_u.pulse(1, 1);
        chk("prog", 8'h01, programMode);
        chk("oe", 8'h00, dataOe);
        arst_n = 1'b0;
        @(negedge core_clk) arst_n = 1'b1;
        chk("prog", 8'h00, programMode);
    endtask
    // reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        t_read();
        t_standby();
        t_resume();
        t_prog();
        close_out();
    end
endmodule
`default_nettype wire
